// File: verilog/phy_status_pkg.sv
// Constants and types for the management status and identifier registers
package phy_status_pkg;

  // ****************************************
  // Register access
  // ****************************************
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_BASIC_STATUS     = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_IDENTIFIER_UPPER = 5'h02;

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  // ****************************************
  // Status word fixed values
  // ****************************************
  localparam logic       CAP_T4          = 1'h0;
  localparam logic       CAP_TX_FULL     = 1'h1;
  localparam logic       CAP_TX_HALF     = 1'h1;
  localparam logic       CAP_T_FULL      = 1'h1;
  localparam logic       CAP_T_HALF      = 1'h1;
  localparam logic [2:0] STATUS_RESERVED = 3'h0;
  localparam logic       CAP_UNIDIR      = 1'h1;
  localparam logic       CAP_PRE_SUPPR   = 1'h1;
  localparam logic       CAP_AUTONEG     = 1'h1;
  localparam logic       CAP_EXTENDED    = 1'h1;

  localparam logic FLAG_RESET = 1'h0;

  // ****************************************
  // Identifier layout
  // ****************************************
  localparam int unsigned ORG_ID_W = 24;
  // Organisation identifier bit 3 sits at vector index 21, bit 18 at index 6
  localparam int unsigned ID_UPPER_HI = 21;
  localparam int unsigned ID_UPPER_LO = 6;
  // Arbitrary neutral value
  localparam logic [ORG_ID_W-1:0] ORG_ID_DEFAULT = 24'h5A3C96;

  // ****************************************
  // Latch-high flag indices
  // ****************************************
  localparam int unsigned LH_REMOTE_FAULT = 0;
  localparam int unsigned LH_JABBER       = 1;
  localparam int unsigned LH_COUNT        = 2;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic       cap_t4;
    logic       cap_tx_full;
    logic       cap_tx_half;
    logic       cap_t_full;
    logic       cap_t_half;
    logic [2:0] reserved;
    logic       cap_unidir;
    logic       cap_pre_suppr;
    logic       an_complete;
    logic       remote_fault;
    logic       cap_autoneg;
    logic       link_up;
    logic       jabber;
    logic       cap_extended;
  } basic_status_t;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef enum logic {
    LINK_DOWN,
    LINK_UP
  } link_state_t;

endpackage : phy_status_pkg

// File: verilog/latch_high_flag.sv
// Sticky flag that sets on an event and clears on a status read
module latch_high_flag (
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  input  wire logic CE_I,
  input  wire logic event_i,
  input  wire logic clear_i,
  output logic      flag_o
);

  logic flag_r;
  logic flag_nxt;

  // ****************************************
  // Set wins over a clear in the same cycle
  // ****************************************
  always_comb begin
    flag_nxt = flag_r;
    if (event_i) begin
      flag_nxt = 1'h1;
    end else if (clear_i) begin
      flag_nxt = phy_status_pkg::FLAG_RESET;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      flag_r <= phy_status_pkg::FLAG_RESET;
    end else if (CE_I) begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;

endmodule : latch_high_flag

// File: verilog/latch_low_link.sv
// Link status that drops on failure and re-arms only on a status read
module latch_low_link (
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  input  wire logic CE_I,
  input  wire logic link_good_i,
  input  wire logic rearm_i,
  output logic      link_o
);

  phy_status_pkg::link_state_t state_r;
  phy_status_pkg::link_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      phy_status_pkg::LINK_UP: begin
        if (!link_good_i) begin
          state_nxt = phy_status_pkg::LINK_DOWN;
        end
      end
      default: begin
        if (link_good_i && rearm_i) begin
          state_nxt = phy_status_pkg::LINK_UP;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= phy_status_pkg::LINK_DOWN;
    end else if (CE_I) begin
      state_r <= state_nxt;
    end
  end

  // Failure shows at once, not one cycle later
  assign link_o = (state_r == phy_status_pkg::LINK_UP) && link_good_i;

endmodule : latch_low_link

// File: verilog/phy_status_regs.sv
// Management status and identifier registers of a 10/100 transceiver
//
// How it works
// R1: Bit 15 reads 0, no four-pair mode
// R2: Bits 14 to 11 read constant 1
// R3: Reserved bits 10:8 read 000; host writes 0
// R4: Bit 7 reads 1, unidirectional transmit
// R5: Bit 6 reads 1, preamble may be omitted
// R6: Host sends full preamble after reset/errors; mgmt_host drives a parallel strobe port and sends no preamble
// R7: Bit 5 shows auto-negotiation complete, resets 0
// R8: Bit 4 latches remote fault until read
// R9: Bit 3 reads 1, auto-negotiation able
// R10: Bit 2 link up, resets 0, drops immediately
// R11: Link re-arms only with good link and read
// R12: Bit 1 latches jabber in 10 Mb/s
// R13: Bit 0 reads 1, extended registers present
// R14: Identifier registers form 32-bit organisation/model/revision; only the upper register at address 2 is implemented, address 3 reads zero
// R15: Upper identifier holds organisation bits 3 to 18
// R16: Identifier may optionally read all zero
// R17: Read captures flags before clear or re-arm
module phy_status_regs #(
  parameter logic [phy_status_pkg::ORG_ID_W-1:0] ORG_ID   = phy_status_pkg::ORG_ID_DEFAULT,
  parameter bit                                  ID_BLANK = 1'b0
) (
  input  wire logic                              CLK_I,
  input  wire logic                              RST_N_I,
  input  wire logic                              CE_I,
  input  wire logic                              REG_RD_I,
  input  wire logic                              REG_WR_I,
  input  wire logic [phy_status_pkg::ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [phy_status_pkg::DATA_W-1:0] REG_WDATA_I,
  output logic      [phy_status_pkg::DATA_W-1:0] REG_RDATA_O,
  output logic                                   REG_RVALID_O,
  input  wire logic                              AN_DONE_I,
  input  wire logic                              FAR_END_FAULT_I,
  input  wire logic                              LP_REMOTE_FAULT_I,
  input  wire logic                              LINK_GOOD_I,
  input  wire logic                              JABBER_I,
  input  wire logic                              SPEED_10_I
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic addr_hit(
    input logic [phy_status_pkg::ADDR_W-1:0] addr,
    input logic [phy_status_pkg::ADDR_W-1:0] target
  );
    addr_hit = (addr == target);
  endfunction : addr_hit

  phy_status_pkg::reg_req_t req;
  logic                     status_read;

  assign req.rd    = REG_RD_I;
  assign req.wr    = REG_WR_I;
  assign req.addr  = REG_ADDR_I;
  assign req.wdata = REG_WDATA_I;

  // Writes to both registers are ignored; req.wr and req.wdata have no effect
  assign status_read = req.rd && addr_hit(req.addr, phy_status_pkg::ADDR_BASIC_STATUS);

  // ****************************************
  // Auto-negotiation complete
  // ****************************************
  logic an_done_r;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      an_done_r <= phy_status_pkg::FLAG_RESET; // see R7
    end else if (CE_I) begin
      an_done_r <= AN_DONE_I; // see R7
    end
  end

  // ****************************************
  // Latch-high flags
  // ****************************************
  logic [phy_status_pkg::LH_COUNT-1:0] lh_event;
  logic [phy_status_pkg::LH_COUNT-1:0] lh_flag;

  assign lh_event[phy_status_pkg::LH_REMOTE_FAULT] = FAR_END_FAULT_I || LP_REMOTE_FAULT_I; // see R8
  assign lh_event[phy_status_pkg::LH_JABBER]       = JABBER_I && SPEED_10_I; // see R12

  genvar gi;
  generate
    for (gi = 0; gi < phy_status_pkg::LH_COUNT; gi++) begin : g_lh
      // Clear lands on the same edge that captures the read data
      latch_high_flag u_flag (
        .CLK_I   (CLK_I),
        .RST_N_I (RST_N_I),
        .CE_I    (CE_I),
        .event_i (lh_event[gi]),
        .clear_i (status_read), // see R17
        .flag_o  (lh_flag[gi])
      );
    end
  endgenerate

  // ****************************************
  // Latch-low link status
  // ****************************************
  logic link_up;

  latch_low_link u_link (
    .CLK_I       (CLK_I),
    .RST_N_I     (RST_N_I),
    .CE_I        (CE_I),
    .link_good_i (LINK_GOOD_I), // see R10
    .rearm_i     (status_read), // see R11
    .link_o      (link_up)
  );

  // ****************************************
  // Read data assembly
  // ****************************************
  phy_status_pkg::basic_status_t status_word;
  logic [phy_status_pkg::DATA_W-1:0] id_upper;

  always_comb begin
    status_word.cap_t4        = phy_status_pkg::CAP_T4; // see R1
    status_word.cap_tx_full   = phy_status_pkg::CAP_TX_FULL; // see R2
    status_word.cap_tx_half   = phy_status_pkg::CAP_TX_HALF; // see R2
    status_word.cap_t_full    = phy_status_pkg::CAP_T_FULL; // see R2
    status_word.cap_t_half    = phy_status_pkg::CAP_T_HALF; // see R2
    status_word.reserved      = phy_status_pkg::STATUS_RESERVED; // see R3
    status_word.cap_unidir    = phy_status_pkg::CAP_UNIDIR; // see R4
    status_word.cap_pre_suppr = phy_status_pkg::CAP_PRE_SUPPR; // see R5
    status_word.an_complete   = an_done_r; // see R7
    status_word.remote_fault  = lh_flag[phy_status_pkg::LH_REMOTE_FAULT]; // see R8
    status_word.cap_autoneg   = phy_status_pkg::CAP_AUTONEG; // see R9
    status_word.link_up       = link_up; // see R10
    status_word.jabber        = lh_flag[phy_status_pkg::LH_JABBER]; // see R12
    status_word.cap_extended  = phy_status_pkg::CAP_EXTENDED; // see R13
  end

  // Upper half of the 32-bit identifier; top two organisation bits dropped
  assign id_upper = ID_BLANK ? phy_status_pkg::DATA_ZERO :
                    ORG_ID[phy_status_pkg::ID_UPPER_HI:phy_status_pkg::ID_UPPER_LO]; // see R14, R15, R16

  // ****************************************
  // Read port
  // ****************************************
  logic [phy_status_pkg::DATA_W-1:0] rdata_r;
  logic [phy_status_pkg::DATA_W-1:0] rdata_nxt;
  logic                              rvalid_r;

  always_comb begin
    if (addr_hit(req.addr, phy_status_pkg::ADDR_BASIC_STATUS)) begin
      rdata_nxt = status_word; // see R17
    end else if (addr_hit(req.addr, phy_status_pkg::ADDR_IDENTIFIER_UPPER)) begin
      rdata_nxt = id_upper;
    end else begin
      rdata_nxt = phy_status_pkg::DATA_ZERO;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rdata_r <= phy_status_pkg::DATA_ZERO;
    end else if (CE_I && req.rd) begin
      rdata_r <= rdata_nxt; // see R17
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rvalid_r <= phy_status_pkg::FLAG_RESET;
    end else if (CE_I) begin
      rvalid_r <= req.rd;
    end
  end

  assign REG_RDATA_O  = rdata_r;
  assign REG_RVALID_O = rvalid_r;

endmodule : phy_status_regs

// File: tb/phy_status_checker.sv
// Assertions on the status and identifier register ports
module phy_status_checker #(
  parameter logic [phy_status_pkg::ORG_ID_W-1:0] ORG_ID   = phy_status_pkg::ORG_ID_DEFAULT,
  parameter bit                                  ID_BLANK = 1'b0
) (
  input wire logic                              CLK_I,
  input wire logic                              RST_N_I,
  input wire logic                              REG_RD_I,
  input wire logic [phy_status_pkg::ADDR_W-1:0] REG_ADDR_I,
  input wire logic [phy_status_pkg::DATA_W-1:0] REG_RDATA_O,
  input wire logic                              REG_RVALID_O,
  input wire logic                              AN_DONE_I,
  input wire logic                              FAR_END_FAULT_I,
  input wire logic                              LP_REMOTE_FAULT_I,
  input wire logic                              LINK_GOOD_I,
  input wire logic                              JABBER_I,
  input wire logic                              SPEED_10_I
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Read port properties
  // ****************************************
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic st_rd;
  logic was_st;
  assign st_rd  = REG_RD_I && (REG_ADDR_I == phy_status_pkg::ADDR_BASIC_STATUS);
  assign was_st = REG_RVALID_O;
  read_answer_a: assert property ($past(RST_N_I) |-> REG_RVALID_O == $past(REG_RD_I))
    else $error("read valid not one cycle after request");
  fixed_bits_a: assert property (st_rd |=> REG_RDATA_O[15:6] == 10'h1E3 &&
      REG_RDATA_O[3] && REG_RDATA_O[0])
    else $error("status constant bits wrong");
  ident_value_a: assert property (REG_RD_I && REG_ADDR_I == phy_status_pkg::ADDR_IDENTIFIER_UPPER
      |=> REG_RDATA_O == (ID_BLANK ? phy_status_pkg::DATA_ZERO : ORG_ID[21:6]))
    else $error("identifier value wrong");
  fault_latch_a: assert property ((FAR_END_FAULT_I || LP_REMOTE_FAULT_I) ##1 st_rd |=> REG_RDATA_O[4])
    else $error("remote fault not latched");
  fault_clear_a: assert property (st_rd && !FAR_END_FAULT_I && !LP_REMOTE_FAULT_I
      ##1 !FAR_END_FAULT_I && !LP_REMOTE_FAULT_I ##1 st_rd |=> !REG_RDATA_O[4])
    else $error("remote fault not cleared by read");
  jabber_latch_a: assert property (JABBER_I && SPEED_10_I ##1 st_rd |=> REG_RDATA_O[1])
    else $error("jabber not latched");
  link_drop_a: assert property (st_rd && !LINK_GOOD_I |=> !REG_RDATA_O[2])
    else $error("link shown up while link bad");
  link_hold_a: assert property (!LINK_GOOD_I ##1 st_rd |=> !REG_RDATA_O[2])
    else $error("link re-armed without a read");
  link_rearm_a: assert property (st_rd && LINK_GOOD_I ##1 LINK_GOOD_I ##1 st_rd && LINK_GOOD_I
      |=> REG_RDATA_O[2])
    else $error("link not re-armed by read");
  an_done_a: assert property (st_rd && $past(RST_N_I) |=> REG_RDATA_O[5] == $past(AN_DONE_I, 2))
    else $error("negotiation complete bit wrong");
endmodule : phy_status_checker

bind phy_status_regs phy_status_checker #(.ORG_ID(ORG_ID), .ID_BLANK(ID_BLANK)) chk_i (
  .CLK_I, .RST_N_I, .REG_RD_I, .REG_ADDR_I, .REG_RDATA_O, .REG_RVALID_O, .AN_DONE_I,
  .FAR_END_FAULT_I, .LP_REMOTE_FAULT_I, .LINK_GOOD_I, .JABBER_I, .SPEED_10_I
);

// File: tb/mgmt_host.sv
// Station management host model issuing register reads and writes
module mgmt_host (
  input  wire logic                              clk_i,
  output logic                                   rd_o,
  output logic                                   wr_o,
  output logic      [phy_status_pkg::ADDR_W-1:0] addr_o,
  output logic      [phy_status_pkg::DATA_W-1:0] wdata_o,
  input  wire logic [phy_status_pkg::DATA_W-1:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Bus cycles
  // ****************************************
  // Parallel strobe port, no preamble framing to send here
  initial begin
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    addr_o  = 5'h00;
    wdata_o = 16'h0000;
  end
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_o   <= 1'b1;
    addr_o <= a;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_o    <= 1'b1;
    addr_o  <= a;
    wdata_o <= d & 16'hF8FF;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
endmodule : mgmt_host

// File: tb/testbench.sv
// Self-checking testbench for the status and identifier registers
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, an = 1'b0, good = 1'b0, sp10 = 1'b0;
  logic        rd, wr;
  logic [2:0]  ev = 3'h0;
  logic [4:0]  addr, a;
  logic [15:0] wdata, rdata, d, rdata_b;
  logic        rvalid;
  int          fails = 0, cmp_count = 0;
  always #25 clk = ~clk;
  phy_status_regs uut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .REG_RD_I(rd), .REG_WR_I(wr),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
    .AN_DONE_I(an), .FAR_END_FAULT_I(ev[0]), .LP_REMOTE_FAULT_I(ev[1]), .LINK_GOOD_I(good),
    .JABBER_I(ev[2]), .SPEED_10_I(sp10));
  // Second copy with the identifier blanked
  phy_status_regs #(.ID_BLANK(1'b1)) uut_blank (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .REG_RD_I(rd), .REG_WR_I(wr), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata_b),
    .REG_RVALID_O(), .AN_DONE_I(an), .FAR_END_FAULT_I(ev[0]), .LP_REMOTE_FAULT_I(ev[1]),
    .LINK_GOOD_I(good), .JABBER_I(ev[2]), .SPEED_10_I(sp10));
  mgmt_host host (.clk_i(clk), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata));
  // ****************************************
  // Expectations and checks
  // ****************************************
  function automatic logic [15:0] st(logic n, logic r, logic l, logic j);
    return {1'h0, 4'hF, 3'h0, 1'h1, 1'h1, n, r, 1'h1, l, j, 1'h1};
  endfunction : st
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rs(logic [15:0] e);
    host.rd(phy_status_pkg::ADDR_BASIC_STATUS, d);
    chk("status", e, d);
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
  endtask : rs
  task automatic pulse(logic [2:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 3'h0;
  endtask : pulse
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(9));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rs(st(0, 0, 0, 0));
    host.rd(phy_status_pkg::ADDR_IDENTIFIER_UPPER, d);
    chk("ident", phy_status_pkg::ORG_ID_DEFAULT[21:6], d);
    chk("ident blank", 16'h0000, rdata_b);
    pulse(3'h1);
    rs(st(0, 1, 0, 0));
    rs(st(0, 0, 0, 0));
    pulse(3'h2);
    rs(st(0, 1, 0, 0));
    pulse(3'h4);
    rs(st(0, 0, 0, 0));
    sp10 <= 1'b1;
    pulse(3'h4);
    rs(st(0, 0, 0, 1));
    rs(st(0, 0, 0, 0));
    good <= 1'b1;
    rs(st(0, 0, 0, 0));
    rs(st(0, 0, 1, 0));
    an <= 1'b1;
    rs(st(1, 0, 1, 0));
    good <= 1'b0;
    @(posedge clk);
    good <= 1'b1;
    rs(st(1, 0, 0, 0));
    rs(st(1, 0, 1, 0));
    repeat (30) begin
      a = 5'($urandom);
      if (a inside {5'h01, 5'h02}) a = 5'h1F;
      host.wr(a, 16'($urandom));
      host.rd(a, d);
      chk("unmapped", 16'h0000, d);
      host.wr(phy_status_pkg::ADDR_BASIC_STATUS, 16'($urandom));
      rs(st(1, 0, 1, 0));
    end
    // Mid-run reset clears the sticky flags and the link
    pulse(3'h5);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rs(st(1, 0, 0, 0));
    rs(st(1, 0, 1, 0));
    good <= 1'b0;
    rs(st(1, 0, 0, 0));
    conclude();
  end
  initial begin
    #100000;
    fails++;
    conclude();
  end
endmodule : testbench
